// File: logic/ebm_defines.svh
`ifndef EBM_DEFINES_SVH
`define EBM_DEFINES_SVH

// address region decode: top nibble of the transfer address
`define EBM_REGION_MSB      31
`define EBM_REGION_LSB      28
`define EBM_REGION_CS0      4'h1
`define EBM_REGION_CS1      4'h2
`define EBM_REGION_CS2      4'h3
`define EBM_REGION_CS3      4'h4
`define EBM_REGION_CS4      4'h5
`define EBM_REGION_CS5      4'h6

// card mode field of the transfer address
`define EBM_CARD_MODE_MSB   23
`define EBM_CARD_MODE_LSB   21
`define EBM_CARD_ATTR       3'h0
`define EBM_CARD_COMMON     3'h2
`define EBM_CARD_IO         3'h4

// shared pin positions
`define EBM_PIN_ALE         21
`define EBM_PIN_CLE         22
`define EBM_PIN_RNW         25

// reset values and widths
`define EBM_PULLUP_RST      1'h0
`define EBM_FLOAT_W         4
`define EBM_DATA_W          32
`define EBM_ADDR_W          26

`endif

// File: logic/ebm_pkg.sv
package ebm_pkg;

  // owner of the shared pins, one-hot
  typedef enum logic [4:0] {
    OWN_IDLE  = 5'h01,
    OWN_SMC   = 5'h02,
    OWN_SDRAM = 5'h04,
    OWN_FLASH = 5'h08,
    OWN_CARD  = 5'h10
  } ebm_owner_type;

  // pin arbitration state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_OWN   = 3'h2,
    ST_FLOAT = 3'h4
  } ebm_state_type;

endpackage

// File: logic/ebm_float_timer.sv
`include "ebm_defines.svh"

// counts the data float time of the controller that just released the bus
module ebm_float_timer #(
  parameter int FW = `EBM_FLOAT_W
) (
  input  wire logic          clk,      // core clock
  input  wire logic          rst_b,    // async reset, low
  input  wire logic          load,     // start counting
  input  wire logic [FW-1:0] cycles,   // float time in cycles
  output logic               busy      // float time still running
);

  logic [FW-1:0] cnt_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= cycles;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  assign busy = (cnt_r != '0);

endmodule

// File: logic/ebm_pin_mux.sv
// Overview of operation
// RULE1: carry AHB transfers onto external bus pins
// RULE2: one shared bus, driver chosen by region
// RULE3: idle address and controls held stable
// RULE4: wait previous float time before new driver
// RULE5: sdram refresh never stalls other controllers
// RULE6: address regions map onto chip selects
// RULE7: software hands shared pins to bus
// RULE8: data pull-ups enabled after reset
// RULE9: disable bit turns off D0-D15 pull-ups
// RULE10: upper data pull-ups come from io
// RULE11: card direction and selects steer buffer
// RULE12: A22 and byte strobes reused per device
// RULE13: flash chip enable wired outside block; this block drives FLASH_CHIP_SELECT low from own_flash instead
// RULE14: data 8-15 for 16-bit flash only
// RULE15: wait input stretches card cycles
// RULE16: exactly one controller owns the pins
// RULE17: A21 is flash address latch enable
`include "ebm_defines.svh"

module ebm_pin_mux #(
  parameter int DW = `EBM_DATA_W,
  parameter int AW = `EBM_ADDR_W,
  parameter int FW = `EBM_FLOAT_W
) (
  input  wire logic          CORE_CLK,            // 25 MHz clock
  input  wire logic          RST_B,               // async reset, low
  // static memory controller side
  input  wire logic          SMC_REQ,             // wants the pins
  input  wire logic [31:0]   SMC_AHB_ADDR,        // transfer address
  input  wire logic [AW-1:0] SMC_ADDR,            // external address
  input  wire logic [DW-1:0] SMC_WDATA,           // write data
  input  wire logic          SMC_DATA_OE_B,       // drives data, low
  input  wire logic          SMC_RD_B,            // read strobe
  input  wire logic          SMC_WE_B,            // write strobe
  input  wire logic [3:0]    SMC_BS_B,            // byte selects
  input  wire logic [FW-1:0] SMC_FLOAT,           // data float cycles
  input  wire logic          CARD_EN,             // card logic enabled
  input  wire logic          FLASH_WIDE,          // 16-bit flash
  output logic               GRANT_SMC,           // smc owns pins
  output logic               WAIT_TO_SMC,         // stretch card cycle
  // sdram controller side
  input  wire logic          SDR_REQ,             // wants the pins
  input  wire logic          SDR_REFRESH,         // refresh in progress
  input  wire logic [AW-1:0] SDR_ADDR,            // external address
  input  wire logic [DW-1:0] SDR_WDATA,           // write data
  input  wire logic          SDR_DATA_OE_B,       // drives data, low
  input  wire logic          SDR_CS_B,            // sdram select
  input  wire logic [3:0]    SDR_DQM,             // data masks
  input  wire logic [FW-1:0] SDR_FLOAT,           // data float cycles
  output logic               GRANT_SDR,           // sdram owns pins
  // pull-up control
  input  wire logic          DATA_PULLUP_DISABLE, // cfg bit
  output logic               PULLUP_LOW_EN,       // pull-ups D0-D15
  // pins
  input  wire logic          EXTERNAL_WAIT_IN,    // wait pin, low
  input  wire logic [DW-1:0] D_IN,                // data pins in
  output logic [DW-1:0]      D_OUT,               // data pins out
  output logic [DW-1:0]      D_OE_B,              // data enable, low
  output logic [DW-1:0]      RDATA,               // captured data
  output logic [AW-1:0]      A_OUT,               // address pins
  output logic [5:0]         CS_B,                // chip selects
  output logic               SDRAM_CHIP_SELECT,   // sdram select, low
  output logic               RD_B,                // read / card oe
  output logic               WE_B,                // write / card we
  output logic               BYTE_SELECT_1,       // bs1 / io read
  output logic               BYTE_SELECT_3,       // bs3 / io write
  output logic [1:0]         BYTE_SELECT_02,      // bs0, bs2
  output logic               FLASH_READ_STROBE,   // flash oe, low
  output logic               FLASH_WRITE_STROBE,  // flash we, low
  output logic               FLASH_CHIP_SELECT,   // flash ce, low
  output logic               CARD_ENABLE_LOW_BYTE,  // ce1, low
  output logic               CARD_ENABLE_HIGH_BYTE  // ce2, low
);

  // ==========================================================
  // pin input synchroniser
  // ==========================================================
  logic [2:0] wait_sync_r;
  logic       wait_r;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_sync_r <= 3'h7;
      wait_r      <= 1'h1;
    end else begin
      wait_sync_r <= {wait_sync_r[1:0], EXTERNAL_WAIT_IN};
      if (wait_sync_r[2] == wait_sync_r[1]) begin
        wait_r <= wait_sync_r[1];
      end
    end
  end

  // ==========================================================
  // region decode
  // ==========================================================
  logic [3:0] region;
  logic [5:0] cs_hit;
  logic       is_flash;
  logic       is_card;
  logic [2:0] card_mode;
  logic       card_io;

  assign region    = SMC_AHB_ADDR[`EBM_REGION_MSB:`EBM_REGION_LSB];
  assign card_mode = SMC_AHB_ADDR[`EBM_CARD_MODE_MSB:`EBM_CARD_MODE_LSB];
  // RULE6: region to select
  always_comb begin
    cs_hit    = 6'h00;
    cs_hit[0] = (region == `EBM_REGION_CS0);
    cs_hit[1] = (region == `EBM_REGION_CS1);
    cs_hit[2] = (region == `EBM_REGION_CS2);
    cs_hit[3] = (region == `EBM_REGION_CS3);
    cs_hit[4] = (region == `EBM_REGION_CS4);
    cs_hit[5] = (region == `EBM_REGION_CS5);
  end
  assign is_flash = cs_hit[3];
  assign is_card  = CARD_EN && (cs_hit[4] || cs_hit[5]);
  // io and both ide modes use the io strobes
  assign card_io  = card_mode[2];

  // ==========================================================
  // pin arbitration
  // ==========================================================
  ebm_pkg::ebm_state_type state_r;
  ebm_pkg::ebm_state_type state_nxt;
  ebm_pkg::ebm_owner_type owner_r;
  ebm_pkg::ebm_owner_type owner_nxt;
  ebm_pkg::ebm_owner_type want;
  logic [FW-1:0]          float_cycles;
  logic                   float_busy;
  logic                   release_evt;

  // RULE16: one owner only
  always_comb begin
    if (SMC_REQ) begin
      if (is_flash) begin
        want = ebm_pkg::OWN_FLASH;
      end else if (is_card) begin
        want = ebm_pkg::OWN_CARD;
      end else begin
        want = ebm_pkg::OWN_SMC;
      end
    end else if (SDR_REQ || SDR_REFRESH) begin
      want = ebm_pkg::OWN_SDRAM;
    end else begin
      want = ebm_pkg::OWN_IDLE;
    end
  end

  // RULE5: refresh yields to smc
  // an sdram owner gives way as soon as smc asks, even with refresh mid-cycle
  always_comb begin
    state_nxt   = state_r;
    owner_nxt   = owner_r;
    release_evt = 1'b0;
    case (state_r)
      ebm_pkg::ST_IDLE: begin
        if (want != ebm_pkg::OWN_IDLE && !float_busy) begin
          state_nxt = ebm_pkg::ST_OWN;
          owner_nxt = want;
        end
      end
      ebm_pkg::ST_OWN: begin
        if (want != owner_r) begin
          release_evt = 1'b1;
          state_nxt   = ebm_pkg::ST_FLOAT;
          owner_nxt   = ebm_pkg::OWN_IDLE;
        end
      end
      ebm_pkg::ST_FLOAT: begin
        if (!float_busy) begin
          state_nxt = ebm_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = ebm_pkg::ST_IDLE;
        owner_nxt = ebm_pkg::OWN_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= ebm_pkg::ST_IDLE;
      owner_r <= ebm_pkg::OWN_IDLE;
    end else begin
      state_r <= state_nxt;
      owner_r <= owner_nxt;
    end
  end

  // RULE4: previous float time
  assign float_cycles = (owner_r == ebm_pkg::OWN_SDRAM) ? SDR_FLOAT
                                                         : SMC_FLOAT;

  ebm_float_timer #(.FW(FW)) u_float (
    .clk    (CORE_CLK),
    .rst_b  (RST_B),
    .load   (release_evt),
    .cycles (float_cycles),
    .busy   (float_busy)
  );

  // ==========================================================
  // pin drive
  // ==========================================================
  logic own_smc;
  logic own_sdr;
  logic own_flash;
  logic own_card;
  logic [DW-1:0] wdata;
  logic          data_oe_b;
  logic          hi_byte_oe_b;

  assign own_smc   = (owner_r == ebm_pkg::OWN_SMC);
  assign own_sdr   = (owner_r == ebm_pkg::OWN_SDRAM);
  assign own_flash = (owner_r == ebm_pkg::OWN_FLASH);
  assign own_card  = (owner_r == ebm_pkg::OWN_CARD);

  // RULE16: owner enables gate drivers
  // RULE2: owner picks data driver
  assign wdata     = own_sdr ? SDR_WDATA : SMC_WDATA;
  assign data_oe_b = own_sdr ? SDR_DATA_OE_B :
                     (own_smc || own_flash || own_card) ? SMC_DATA_OE_B
                                                        : 1'b1;
  // RULE14: high byte for wide flash
  assign hi_byte_oe_b = data_oe_b || (own_flash && !FLASH_WIDE);

  // RULE1: data path to pins
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      D_OUT  <= '0;
      D_OE_B <= '1;
      RDATA  <= '0;
    end else begin
      D_OUT  <= wdata;
      D_OE_B <= {{(DW-16){data_oe_b || own_flash || own_card}},
                 {8{hi_byte_oe_b}}, {8{data_oe_b}}};
      if (data_oe_b) begin
        RDATA <= D_IN;
      end
    end
  end

  // RULE3: hold address when idle
  // address only updates under an owner, so idle lines never toggle
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      A_OUT <= '0;
    end else if (own_sdr) begin
      A_OUT <= SDR_ADDR;
    end else if (own_smc || own_card) begin
      A_OUT <= SMC_ADDR;
      // RULE11: card buffer direction
      if (own_card) begin
        A_OUT[`EBM_PIN_RNW] <= SMC_WE_B;
      end
    end else if (own_flash) begin
      A_OUT <= SMC_ADDR;
      // RULE17: address latch enable
      A_OUT[`EBM_PIN_ALE] <= SMC_ADDR[`EBM_PIN_ALE];
      // RULE12: A22 as command latch
      A_OUT[`EBM_PIN_CLE] <= SMC_ADDR[`EBM_PIN_CLE];
    end
  end

  // RULE3: controls inactive when idle
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      CS_B                  <= 6'h3F;
      SDRAM_CHIP_SELECT     <= 1'h1;
      RD_B                  <= 1'h1;
      WE_B                  <= 1'h1;
      BYTE_SELECT_1         <= 1'h1;
      BYTE_SELECT_3         <= 1'h1;
      BYTE_SELECT_02        <= 2'h3;
      FLASH_READ_STROBE     <= 1'h1;
      FLASH_WRITE_STROBE    <= 1'h1;
      FLASH_CHIP_SELECT     <= 1'h1;
      CARD_ENABLE_LOW_BYTE  <= 1'h1;
      CARD_ENABLE_HIGH_BYTE <= 1'h1;
    end else begin
      CS_B                  <= ~(cs_hit & {6{own_smc || own_card}});
      SDRAM_CHIP_SELECT     <= !(own_sdr && !SDR_CS_B);
      RD_B                  <= 1'h1;
      WE_B                  <= 1'h1;
      BYTE_SELECT_1         <= 1'h1;
      BYTE_SELECT_3         <= 1'h1;
      BYTE_SELECT_02        <= 2'h3;
      FLASH_READ_STROBE     <= 1'h1;
      FLASH_WRITE_STROBE    <= 1'h1;
      FLASH_CHIP_SELECT     <= !own_flash;
      CARD_ENABLE_LOW_BYTE  <= 1'h1;
      CARD_ENABLE_HIGH_BYTE <= 1'h1;
      // RULE12: strobes reused per device
      if (own_sdr) begin
        BYTE_SELECT_1  <= SDR_DQM[1];
        BYTE_SELECT_3  <= SDR_DQM[3];
        BYTE_SELECT_02 <= {SDR_DQM[2], SDR_DQM[0]};
      end else if (own_smc) begin
        RD_B           <= SMC_RD_B;
        WE_B           <= SMC_WE_B;
        BYTE_SELECT_1  <= SMC_BS_B[1];
        BYTE_SELECT_3  <= SMC_BS_B[3];
        BYTE_SELECT_02 <= {SMC_BS_B[2], SMC_BS_B[0]};
      end else if (own_flash) begin
        FLASH_READ_STROBE  <= SMC_RD_B;
        FLASH_WRITE_STROBE <= SMC_WE_B;
      end else if (own_card) begin
        CARD_ENABLE_LOW_BYTE  <= SMC_BS_B[0];
        CARD_ENABLE_HIGH_BYTE <= SMC_BS_B[1];
        if (card_io) begin
          BYTE_SELECT_1 <= SMC_RD_B;
          BYTE_SELECT_3 <= SMC_WE_B;
        end else begin
          RD_B <= SMC_RD_B;
          WE_B <= SMC_WE_B;
        end
      end
    end
  end

  // ==========================================================
  // grants, wait, pull-ups
  // ==========================================================
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      GRANT_SMC   <= 1'h0;
      GRANT_SDR   <= 1'h0;
      WAIT_TO_SMC <= 1'h0;
    end else begin
      GRANT_SMC   <= (owner_nxt == ebm_pkg::OWN_SMC)
                  || (owner_nxt == ebm_pkg::OWN_FLASH)
                  || (owner_nxt == ebm_pkg::OWN_CARD);
      GRANT_SDR   <= (owner_nxt == ebm_pkg::OWN_SDRAM);
      // RULE15: card wait forwarding
      WAIT_TO_SMC <= own_card && !wait_r;
    end
  end

  // RULE8: pull-ups on after reset
  // RULE9: disable bit for D0-D15
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PULLUP_LOW_EN <= !`EBM_PULLUP_RST;
    end else begin
      PULLUP_LOW_EN <= !DATA_PULLUP_DISABLE;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  chk_single_grant: assert property ( // RULE16
    @(posedge CORE_CLK) disable iff (!RST_B)
    !(GRANT_SMC && GRANT_SDR))
    else $error("both controllers granted");

  chk_float_gap: assert property ( // RULE4
    @(posedge CORE_CLK) disable iff (!RST_B)
    release_evt && float_cycles != '0
    |=> state_r != ebm_pkg::ST_OWN ##1 state_r != ebm_pkg::ST_OWN)
    else $error("new owner before float time");

  chk_idle_addr: assert property ( // RULE3
    @(posedge CORE_CLK) disable iff (!RST_B)
    owner_r == ebm_pkg::OWN_IDLE ##1 owner_r == ebm_pkg::OWN_IDLE
    |=> $stable(A_OUT))
    else $error("address moved while idle");

  chk_idle_ctrl: assert property ( // RULE3
    @(posedge CORE_CLK) disable iff (!RST_B)
    $past(owner_r == ebm_pkg::OWN_IDLE) |-> RD_B && WE_B && (&CS_B))
    else $error("control active while idle");

  chk_pullup_cfg: assert property ( // RULE9
    @(posedge CORE_CLK) disable iff (!RST_B)
    DATA_PULLUP_DISABLE |=> !PULLUP_LOW_EN)
    else $error("pull-up not disabled");

  chk_narrow_flash: assert property ( // RULE14
    @(posedge CORE_CLK) disable iff (!RST_B)
    own_flash && !FLASH_WIDE |=> &D_OE_B[15:8])
    else $error("high byte driven for narrow flash");

  chk_card_wait: assert property ( // RULE15
    @(posedge CORE_CLK) disable iff (!RST_B)
    own_card && !wait_r |=> WAIT_TO_SMC)
    else $error("card wait not forwarded");

  chk_flash_select: assert property ( // RULE17
    @(posedge CORE_CLK) disable iff (!RST_B)
    own_flash |=> !FLASH_CHIP_SELECT
      && A_OUT[`EBM_PIN_ALE] == $past(SMC_ADDR[`EBM_PIN_ALE]))
    else $error("flash latch enable wrong");

  chk_refresh_yield: assert property ( // RULE5
    @(posedge CORE_CLK) disable iff (!RST_B)
    state_r == ebm_pkg::ST_OWN && own_sdr && SMC_REQ |=> !own_sdr)
    else $error("sdram held pins against smc");

endmodule

// File: test/ebm_far_side.sv
// =====================================================================
// far side: memories and card on the shared pins
module ebm_far_side (
  input  wire logic        CORE_CLK,           // bus clock
  input  wire logic [31:0] D_OUT,              // data driven by block
  input  wire logic [31:0] D_OE_B,             // data enable, low
  input  wire logic [25:0] A_OUT,              // address pins
  input  wire logic [5:0]  CS_B,               // chip selects, low
  input  wire logic        RD_B,               // read strobe, low
  input  wire logic        FLASH_READ_STROBE,  // flash read, low
  input  wire logic        FLASH_CHIP_SELECT,  // flash select, low
  input  wire logic        PULLUP_LOW_EN,      // pull-ups D0-D15 on
  input  wire logic        STALL_WAIT,         // card holds wait
  output logic [31:0]      D_IN,               // data pins seen
  output logic             EXTERNAL_WAIT_IN    // wait pin, low
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] drift;
  logic [31:0] word;
  logic        reading;

  // released lines without pull-ups keep changing so a stale value never looks valid
  initial drift = 32'h5A5A5A5A;
  always @(posedge CORE_CLK) drift <= ~drift;

  assign reading = ((CS_B != 6'h3F) || !FLASH_CHIP_SELECT) &&
                   (!RD_B || !FLASH_READ_STROBE);
  assign word = {6'h2A, A_OUT};

  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!D_OE_B[i]) D_IN[i] = D_OUT[i];
      else if (reading) D_IN[i] = word[i];
      else if (i < 16 && PULLUP_LOW_EN) D_IN[i] = 1'b1;
      else D_IN[i] = drift[i];
    end
  end

  assign EXTERNAL_WAIT_IN = !(STALL_WAIT && (!CS_B[4] || !CS_B[5]));
endmodule

// File: test/ebm_pin_mux_test.sv
module ebm_pin_mux_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ===================================================================
  // signals
  logic        CORE_CLK, RST_B, SMC_REQ, SMC_DATA_OE_B, SMC_RD_B;
  logic        SMC_WE_B, CARD_EN, FLASH_WIDE, SDR_REQ, SDR_REFRESH;
  logic        SDR_DATA_OE_B, SDR_CS_B, DATA_PULLUP_DISABLE, STALL_WAIT;
  logic [31:0] SMC_AHB_ADDR, SMC_WDATA, SDR_WDATA, D_IN, D_OUT, D_OE_B;
  logic [31:0] RDATA, wdat, addr32;
  logic [25:0] SMC_ADDR, SDR_ADDR, A_OUT;
  logic [3:0]  SMC_BS_B, SMC_FLOAT, SDR_DQM, SDR_FLOAT;
  logic        GRANT_SMC, GRANT_SDR, WAIT_TO_SMC, PULLUP_LOW_EN;
  logic        EXTERNAL_WAIT_IN, SDRAM_CHIP_SELECT, RD_B, WE_B;
  logic        BYTE_SELECT_1, BYTE_SELECT_3, FLASH_READ_STROBE;
  logic        FLASH_WRITE_STROBE, FLASH_CHIP_SELECT, flag_ok;
  logic        CARD_ENABLE_LOW_BYTE, CARD_ENABLE_HIGH_BYTE;
  logic [1:0]  BYTE_SELECT_02;
  logic [5:0]  CS_B;
  logic [15:0] lfsr;
  logic [35:0] notes[$];
  logic [35:0] nt;
  int          fails, comparisons, n;
  event        look;

  ebm_pin_mux u_ebm_pin_mux (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
    .SMC_REQ(SMC_REQ), .SMC_AHB_ADDR(SMC_AHB_ADDR), .SMC_ADDR(SMC_ADDR),
    .SMC_WDATA(SMC_WDATA), .SMC_DATA_OE_B(SMC_DATA_OE_B),
    .SMC_RD_B(SMC_RD_B), .SMC_WE_B(SMC_WE_B), .SMC_BS_B(SMC_BS_B),
    .SMC_FLOAT(SMC_FLOAT), .CARD_EN(CARD_EN), .FLASH_WIDE(FLASH_WIDE),
    .GRANT_SMC(GRANT_SMC), .WAIT_TO_SMC(WAIT_TO_SMC), .SDR_REQ(SDR_REQ),
    .SDR_REFRESH(SDR_REFRESH), .SDR_ADDR(SDR_ADDR), .SDR_WDATA(SDR_WDATA),
    .SDR_DATA_OE_B(SDR_DATA_OE_B), .SDR_CS_B(SDR_CS_B), .SDR_DQM(SDR_DQM),
    .SDR_FLOAT(SDR_FLOAT), .GRANT_SDR(GRANT_SDR),
    .DATA_PULLUP_DISABLE(DATA_PULLUP_DISABLE),
    .PULLUP_LOW_EN(PULLUP_LOW_EN), .EXTERNAL_WAIT_IN(EXTERNAL_WAIT_IN),
    .D_IN(D_IN), .D_OUT(D_OUT), .D_OE_B(D_OE_B), .RDATA(RDATA),
    .A_OUT(A_OUT), .CS_B(CS_B), .SDRAM_CHIP_SELECT(SDRAM_CHIP_SELECT),
    .RD_B(RD_B), .WE_B(WE_B), .BYTE_SELECT_1(BYTE_SELECT_1),
    .BYTE_SELECT_3(BYTE_SELECT_3), .BYTE_SELECT_02(BYTE_SELECT_02),
    .FLASH_READ_STROBE(FLASH_READ_STROBE),
    .FLASH_WRITE_STROBE(FLASH_WRITE_STROBE),
    .FLASH_CHIP_SELECT(FLASH_CHIP_SELECT),
    .CARD_ENABLE_LOW_BYTE(CARD_ENABLE_LOW_BYTE),
    .CARD_ENABLE_HIGH_BYTE(CARD_ENABLE_HIGH_BYTE));

  ebm_far_side u_ebm_far_side (.CORE_CLK(CORE_CLK), .D_OUT(D_OUT),
    .D_OE_B(D_OE_B), .A_OUT(A_OUT), .CS_B(CS_B), .RD_B(RD_B),
    .FLASH_READ_STROBE(FLASH_READ_STROBE),
    .FLASH_CHIP_SELECT(FLASH_CHIP_SELECT), .PULLUP_LOW_EN(PULLUP_LOW_EN),
    .STALL_WAIT(STALL_WAIT), .D_IN(D_IN),
    .EXTERNAL_WAIT_IN(EXTERNAL_WAIT_IN));

  always #20 CORE_CLK = ~CORE_CLK;

  // ===================================================================
  // helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    rnd = {lfsr, lfsr[7:0], lfsr[15:8]};
  endfunction

  function automatic logic pick(input int w);
    pick = (w == 0) ? GRANT_SMC : GRANT_SDR;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge CORE_CLK);
  endtask

  task automatic probe(input logic [3:0] k, input logic [31:0] e);
    notes.push_back({k, e});
    -> look;
  endtask

  // a grant that never comes must not hang the run
  task automatic wait_for(input int w, input logic v, output int c);
    c = 0;
    while (pick(w) !== v) begin
      @(negedge CORE_CLK);
      c++;
      if (c > 60) begin
        fails++;
        $display("BAD %0t wait ran out", $time);
        close_out();
      end
    end
  endtask

  task automatic smc_on(input logic [3:0] rg, input logic [2:0] md,
                        input logic wr);
    @(posedge CORE_CLK);
    SMC_AHB_ADDR  <= {rg, 4'h0, md, 21'h000000};
    SMC_ADDR      <= addr32[25:0];
    SMC_WDATA     <= wdat;
    SMC_DATA_OE_B <= ~wr;
    SMC_RD_B      <= wr;
    SMC_WE_B      <= ~wr;
    SMC_REQ       <= 1'b1;
    wait_for(0, 1'b1, n);
    cyc(2);
  endtask

  task automatic smc_off();
    @(posedge CORE_CLK);
    SMC_REQ       <= 1'b0;
    SMC_RD_B      <= 1'b1;
    SMC_WE_B      <= 1'b1;
    SMC_DATA_OE_B <= 1'b1;
  endtask

  // ===================================================================
  // watcher: compares every queued note, oldest first, with the outputs or with flag_ok
  initial forever begin
    @(look);
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt[35:32])
        4'h1: check({31'h0, GRANT_SDR}, nt[31:0]);
        4'h2: check({26'h0, CS_B}, nt[31:0]);
        4'h3: check(D_OUT, nt[31:0]);
        4'h4: check(D_OE_B, nt[31:0]);
        4'h5: check(RDATA, nt[31:0]);
        4'h6: check({31'h0, PULLUP_LOW_EN}, nt[31:0]);
        4'h7: check({28'h0, FLASH_READ_STROBE, FLASH_WRITE_STROBE,
                     FLASH_CHIP_SELECT, A_OUT[21]}, nt[31:0]);
        4'h8: check({27'h0, CARD_ENABLE_HIGH_BYTE, CARD_ENABLE_LOW_BYTE,
                     RD_B, BYTE_SELECT_1, A_OUT[25]}, nt[31:0]);
        4'h9: check({27'h0, BYTE_SELECT_02, BYTE_SELECT_1, BYTE_SELECT_3,
                     SDRAM_CHIP_SELECT}, nt[31:0]);
        4'hA: check({31'h0, WAIT_TO_SMC}, nt[31:0]);
        4'hB: check({24'h0, CS_B, RD_B, WE_B}, nt[31:0]);
        4'hC: check(D_OE_B, nt[31:0]);
        4'hD: check({31'h0, flag_ok}, nt[31:0]);
        4'hE: check({31'h0, flag_ok}, nt[31:0]);
        default: check({16'h0, RDATA[15:0]}, nt[31:0]);
      endcase
    end
  end

  always @(negedge CORE_CLK) begin
    if (RST_B === 1'b1) check({31'h0, GRANT_SMC & GRANT_SDR}, 32'h0);
  end

  // ===================================================================
  // main sequence
  logic [2:0] cmode[4] = '{3'h0, 3'h2, 3'h4, 3'h2};
  logic [2:0] cexp[4]  = '{3'h3, 3'h3, 3'h5, 3'h6};

  initial begin
    {CORE_CLK, RST_B, SMC_REQ, CARD_EN, FLASH_WIDE, SDR_REQ} = 6'h00;
    {SDR_REFRESH, DATA_PULLUP_DISABLE, STALL_WAIT} = 3'h0;
    {SMC_DATA_OE_B, SMC_RD_B, SMC_WE_B, SDR_DATA_OE_B, SDR_CS_B} = 5'h1F;
    SMC_AHB_ADDR = 32'h0;
    SMC_WDATA = 32'h0;
    SDR_WDATA = 32'h0;
    SMC_ADDR = 26'h0;
    SDR_ADDR = 26'h0;
    {SMC_BS_B, SDR_DQM, SMC_FLOAT, SDR_FLOAT} = 16'hFF32;
    lfsr = 16'h5D2D;
    fails = 0;
    comparisons = 0;
    repeat (8) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    cyc(3);
    probe(4'hB, 32'hFF);
    probe(4'hF, 32'hFFFF);
    probe(4'h6, 32'h1);
    @(posedge CORE_CLK);
    DATA_PULLUP_DISABLE <= 1'b1;
    cyc(3);
    probe(4'h6, 32'h0);
    @(posedge CORE_CLK);
    DATA_PULLUP_DISABLE <= 1'b0;
    cyc(3);
    probe(4'h6, 32'h1);
    for (int r = 1; r <= 6; r++) begin
      addr32 = rnd();
      wdat = rnd();
      smc_on(r[3:0], 3'h0, 1'b1);
      if (r == 4) begin
        probe(4'h7, {28'h0, 2'b10, 1'b0, addr32[21]});
        probe(4'hC, 32'hFFFFFF00);
      end else begin
        probe(4'h2, 32'h3F ^ (32'h1 << (r - 1)));
        probe(4'h3, wdat);
        probe(4'h4, 32'h0);
      end
      smc_off();
      addr32 = rnd();
      SMC_ADDR <= addr32[25:0];
      SMC_AHB_ADDR <= rnd();
      cyc(7);
      probe(4'hB, 32'hFF);
    end
    @(posedge CORE_CLK);
    FLASH_WIDE <= 1'b1;
    smc_on(4'h4, 3'h0, 1'b1);
    probe(4'hC, 32'hFFFF0000);
    smc_off();
    cyc(7);
    addr32 = rnd();
    smc_on(4'h1, 3'h0, 1'b0);
    cyc(2);
    probe(4'h5, {6'h2A, addr32[25:0]});
    smc_off();
    CARD_EN <= 1'b1;
    cyc(7);
    for (int m = 0; m < 4; m++) begin
      smc_on(4'h5, cmode[m], m == 3);
      probe(4'h8, {27'h0, 2'h3, cexp[m]});
      if (m == 2) begin
        @(posedge CORE_CLK);
        STALL_WAIT <= 1'b1;
        cyc(6);
        probe(4'hA, 32'h1);
        @(posedge CORE_CLK);
        STALL_WAIT <= 1'b0;
        cyc(6);
        probe(4'hA, 32'h0);
      end
      smc_off();
      cyc(7);
    end
    @(posedge CORE_CLK);
    SMC_FLOAT <= 4'h5;
    smc_on(4'h1, 3'h0, 1'b1);
    smc_off();
    wdat = rnd();
    {SDR_REQ, SDR_CS_B, SDR_DATA_OE_B, SDR_REFRESH} <= 4'h9;
    {SDR_DQM, SDR_WDATA, SDR_ADDR} <= {4'h2, wdat, addr32[25:0]};
    wait_for(1, 1'b1, n);
    flag_ok = (n > 5) && (n < 14);
    probe(4'hD, 32'h1);
    cyc(2);
    probe(4'h9, 32'h4);
    probe(4'h3, wdat);
    @(posedge CORE_CLK);
    SMC_REQ <= 1'b1;
    wait_for(0, 1'b1, n);
    flag_ok = (n < 11);
    probe(4'hE, 32'h1);
    probe(4'h1, 32'h0);
    smc_off();
    {SDR_REQ, SDR_CS_B, SDR_DATA_OE_B, SDR_REFRESH} <= 4'h6;
    cyc(12);
    close_out();
  end
endmodule
